// ### rtl/mode_switch_reset_sequencer.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "mode_switch_reset_sequencer_map.svh"
module mode_switch_reset_sequencer #(
  parameter int          RAM_AW     = 16,
  parameter int          BLINK_W    = 26,
  parameter logic [39:0] HOLD_CYC   = `HOLD_MS * `CLK_KHZ,
  parameter logic [39:0] TAP_CYC    = `TAP_MS * `CLK_KHZ,
  parameter logic [39:0] FTAP_CYC   = `FACT_TAP_MS * `CLK_KHZ,
  parameter logic [39:0] OFFER_CYC  = `FW_OFFER_MS * `CLK_KHZ,
  parameter logic [39:0] BOOT_CYC   = `BOOT_MS * `CLK_KHZ,
  parameter logic [39:0] PHASE_CYC  = `PHASE_MS * `CLK_KHZ,
  parameter logic [39:0] DEB_CYC    = `DEBOUNCE_MS * `CLK_KHZ
) (
  input  wire logic                                  core_clk,
  input  wire logic                                  rst,
  input  wire logic                                  run_position_pin,
  input  wire logic                                  memory_clear_position_pin,
  input  wire logic                                  card_present,
  input  wire logic                                  card_cmd_factory,
  input  wire mode_switch_reset_sequencer_pkg::pkg_info_t card_pkg,
  input  wire logic [15:0]                           installed_version,
  output logic                                       card_reload_req,
  input  wire logic                                  card_reload_done,
  output logic                                       fw_write_req,
  input  wire logic                                  fw_write_done,
  input  wire logic                                  fw_write_err,
  output logic                                       ram_clr_we,
  output logic [RAM_AW-1:0]                          ram_clr_addr,
  output logic [31:0]                                pg_net_addr,
  output logic [6:0]                                 multipoint_station_address,
  output logic                                       run_mode,
  output mode_switch_reset_sequencer_pkg::led_t      led,
  input  wire logic [7:0]                            reg_addr,
  input  wire logic [31:0]                           reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic [31:0]                                reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Lever synchroniser and debouncer

  logic [1:0] pin_raw;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] deb;
  logic [1:0] deb_prev;

  assign pin_raw = {memory_clear_position_pin, run_position_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_deb
      logic [39:0] cnt;
      logic [39:0] next_cnt;
      logic        next_deb;
      always_comb
      begin
        next_cnt = 40'h00_0000_0000;
        next_deb = deb[gi];
        if (sync2[gi] != deb[gi])
        begin
          next_cnt = cnt + 40'h00_0000_0001;
          if (cnt >= DEB_CYC - 40'h00_0000_0001)
          begin
            next_deb = sync2[gi];
            next_cnt = 40'h00_0000_0000;
          end
        end
      end
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          deb[gi]   <= 1'b0;
          cnt       <= 40'h00_0000_0000;
        end
        else
        begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          deb[gi]   <= next_deb;
          cnt       <= next_cnt;
        end
      end
    end
  endgenerate

  logic sel_run;
  logic sel_memory_clear_position;
  logic memory_clear_position_rise;
  assign sel_run   = deb[0];
  assign sel_memory_clear_position  = deb[1];
  assign memory_clear_position_rise = deb[1] & ~deb_prev[1];

  ////////////////////////////////////////////////////////////////////////////
  // Blink sources, free running

  logic [BLINK_W-1:0] blink_cnt;
  logic               blink_slow;
  logic               blink_fast;
  assign blink_slow = blink_cnt[BLINK_W-1];
  assign blink_fast = blink_cnt[BLINK_W-3];

  ////////////////////////////////////////////////////////////////////////////
  // Firmware package check

  function automatic logic name_ok(input logic [63:0] n);
    logic ok;
    ok = (n[63:56] == 8'h70 || n[63:56] == 8'h50) && n[55:48] == 8'h78;
    for (int i = 0; i < 6; i++)
    begin
      ok = ok && n[i*8 +: 8] >= 8'h30 && n[i*8 +: 8] <= 8'h39;
    end
    return ok;
  endfunction : name_ok

  logic fw_newer;
  assign fw_newer = card_present && card_pkg.valid && name_ok(card_pkg.name)
                    && card_pkg.version != installed_version;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  mode_switch_reset_sequencer_pkg::seq_state_t state;
  mode_switch_reset_sequencer_pkg::seq_state_t next_state;
  mode_switch_reset_sequencer_pkg::led_t       next_led;
  logic [39:0]       timer;
  logic [39:0]       next_timer;
  logic [2:0]        steady_cnt;
  logic [2:0]        next_steady_cnt;
  logic              steady;
  logic              next_steady;
  logic              factory;
  logic              next_factory;
  logic              fw_mode;
  logic              next_fw_mode;
  logic              fw_err;
  logic              next_fw_err;
  logic              next_run_mode;
  logic [RAM_AW-1:0] next_clr_addr;
  logic [31:0]       next_net;
  logic [6:0]        next_station;
  logic              remote_clear;
  logic              clear_done;

  assign remote_clear = reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_CLEAR_BIT];
  assign clear_done   = ram_clr_addr == {RAM_AW{1'b1}};
  assign ram_clr_we      = state == mode_switch_reset_sequencer_pkg::ST_CLEAR;
  assign card_reload_req = state == mode_switch_reset_sequencer_pkg::ST_RELOAD;
  assign fw_write_req    = state == mode_switch_reset_sequencer_pkg::ST_FW_WRITE;

  always_comb
  begin
    next_state      = state;
    next_timer      = timer + 40'h00_0000_0001;
    next_steady_cnt = steady_cnt;
    next_steady     = steady;
    next_factory    = factory;
    next_fw_mode    = fw_mode;
    next_fw_err     = fw_err;
    next_run_mode   = run_mode;
    next_clr_addr   = ram_clr_addr;
    next_net        = pg_net_addr;
    next_station    = multipoint_station_address;
    if (reg_wr && reg_addr == `REG_NET)
      next_net = reg_wdata;
    if (reg_wr && reg_addr == `REG_STATION)
      next_station = reg_wdata[6:0];
    case (state)
      mode_switch_reset_sequencer_pkg::ST_BOOT:
        if (timer >= BOOT_CYC - 40'h00_0000_0001)
        begin
          next_state = fw_newer ? mode_switch_reset_sequencer_pkg::ST_FW_OFFER
                                : mode_switch_reset_sequencer_pkg::ST_IDLE;
          next_timer = 40'h00_0000_0000;
        end
      mode_switch_reset_sequencer_pkg::ST_FW_OFFER:
        if (memory_clear_position_rise)
          next_state = mode_switch_reset_sequencer_pkg::ST_FW_WRITE;
        else if (timer >= OFFER_CYC - 40'h00_0000_0001)
          next_state = mode_switch_reset_sequencer_pkg::ST_IDLE;
      mode_switch_reset_sequencer_pkg::ST_FW_WRITE:
        if (fw_write_done)
        begin
          next_fw_err   = fw_write_err;
          next_fw_mode  = 1'b1;
          next_clr_addr = '0;
          next_state    = mode_switch_reset_sequencer_pkg::ST_CLEAR;
        end
      mode_switch_reset_sequencer_pkg::ST_IDLE:
      begin
        next_run_mode = sel_run;
        next_timer    = 40'h00_0000_0000;
        if (!run_mode && !sel_run)
        begin
          if (memory_clear_position_rise)
          begin
            next_state      = mode_switch_reset_sequencer_pkg::ST_HOLD;
            next_steady     = 1'b0;
            next_steady_cnt = 3'd0;
            next_factory    = 1'b0;
          end
          else if (remote_clear || card_cmd_factory)
          begin
            next_factory  = card_cmd_factory;
            next_clr_addr = '0;
            next_state    = mode_switch_reset_sequencer_pkg::ST_CLEAR;
          end
        end
      end
      mode_switch_reset_sequencer_pkg::ST_HOLD:
        if (!sel_memory_clear_position)
        begin
          next_timer = 40'h00_0000_0000;
          next_state = steady_cnt == 3'd0 ? mode_switch_reset_sequencer_pkg::ST_IDLE
                                          : mode_switch_reset_sequencer_pkg::ST_ARMED;
        end
        else if (steady_cnt == 3'd0 ? timer >= HOLD_CYC - 40'h00_0000_0001
                                    : timer >= PHASE_CYC - 40'h00_0000_0001)
        begin
          next_timer  = 40'h00_0000_0000;
          next_steady = !steady;
          if (!steady && steady_cnt != 3'd7)
            next_steady_cnt = steady_cnt + 3'd1;
        end
      mode_switch_reset_sequencer_pkg::ST_ARMED:
        if (memory_clear_position_rise)
        begin
          next_factory  = steady_cnt == `FACT_STEADY;
          next_clr_addr = '0;
          next_state    = mode_switch_reset_sequencer_pkg::ST_CLEAR;
        end
        else if (steady_cnt == `FACT_STEADY)
        begin
          if (timer >= FTAP_CYC - 40'h00_0000_0001)
          begin
            next_clr_addr = '0;
            next_state    = mode_switch_reset_sequencer_pkg::ST_CLEAR;
          end
        end
        else if (timer >= TAP_CYC - 40'h00_0000_0001)
          next_state = mode_switch_reset_sequencer_pkg::ST_IDLE;
      mode_switch_reset_sequencer_pkg::ST_CLEAR:
      begin
        next_clr_addr = ram_clr_addr + 1'b1;
        if (factory)
        begin
          next_net     = `NET_RESET;
          next_station = `STATION_RESET;
        end
        if (clear_done)
          next_state = fw_mode ? mode_switch_reset_sequencer_pkg::ST_FW_END
                       : card_present ? mode_switch_reset_sequencer_pkg::ST_RELOAD
                                      : mode_switch_reset_sequencer_pkg::ST_IDLE;
      end
      mode_switch_reset_sequencer_pkg::ST_RELOAD:
        if (card_reload_done || !card_present)
        begin
          next_run_mode = sel_run;
          next_state    = mode_switch_reset_sequencer_pkg::ST_IDLE;
        end
      mode_switch_reset_sequencer_pkg::ST_FW_END:
        next_state = state;
      default:
        next_state = mode_switch_reset_sequencer_pkg::ST_IDLE;
    endcase
  end

  // Indicator pattern, registered one cycle behind the state
  always_comb
  begin
    next_led       = '0;
    next_led.power = 1'b1;
    next_led.run   = run_mode | factory;
    case (state)
      mode_switch_reset_sequencer_pkg::ST_FW_OFFER,
      mode_switch_reset_sequencer_pkg::ST_FW_WRITE:
      begin
        next_led.fault     = blink_slow;
        next_led.force_ind = !blink_slow;
        next_led.card      = state == mode_switch_reset_sequencer_pkg::ST_FW_WRITE;
        next_led.stop      = 1'b1;
      end
      mode_switch_reset_sequencer_pkg::ST_HOLD:
        next_led.stop = steady | blink_slow;
      mode_switch_reset_sequencer_pkg::ST_CLEAR:
      begin
        next_led.stop      = fw_mode ? 1'b1 : blink_slow;
        next_led.fault     = fw_mode & blink_slow;
        next_led.force_ind = fw_mode & !blink_slow;
        next_led.card      = fw_mode;
      end
      mode_switch_reset_sequencer_pkg::ST_RELOAD:
      begin
        next_led.stop = 1'b1;
        next_led.card = blink_slow;
      end
      mode_switch_reset_sequencer_pkg::ST_FW_END:
      begin
        next_led.power     = fw_err ? blink_fast : 1'b1;
        next_led.stop      = fw_err ? blink_fast : 1'b1;
        next_led.fault     = fw_err ? blink_fast : 1'b1;
        next_led.force_ind = fw_err ? blink_fast : 1'b1;
        next_led.card      = fw_err ? blink_fast : 1'b1;
      end
      default:
        next_led.stop = !run_mode;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state                      <= mode_switch_reset_sequencer_pkg::ST_BOOT;
      timer                      <= 40'h00_0000_0000;
      steady_cnt                 <= 3'd0;
      steady                     <= 1'b0;
      factory                    <= 1'b0;
      fw_mode                    <= 1'b0;
      fw_err                     <= 1'b0;
      run_mode                   <= 1'b0;
      ram_clr_addr               <= '0;
      pg_net_addr                <= `NET_RESET;
      multipoint_station_address <= `STATION_RESET;
      led                        <= '0;
      blink_cnt                  <= '0;
      deb_prev                   <= 2'b00;
    end
    else
    begin
      state                      <= next_state;
      timer                      <= next_timer;
      steady_cnt                 <= next_steady_cnt;
      steady                     <= next_steady;
      factory                    <= next_factory;
      fw_mode                    <= next_fw_mode;
      fw_err                     <= next_fw_err;
      run_mode                   <= next_run_mode;
      ram_clr_addr               <= next_clr_addr;
      pg_net_addr                <= next_net;
      multipoint_station_address <= next_station;
      led                        <= next_led;
      blink_cnt                  <= blink_cnt + 1'b1;
      deb_prev                   <= deb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port; unmapped offsets read zero

  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `REG_STATUS:
        begin
          next_rdata[`STAT_RUN_BIT]   = run_mode;
          next_rdata[`STAT_FWERR_BIT] = fw_err;
          next_rdata[`STAT_FACT_BIT]  = factory;
          next_rdata[`STAT_STATE_LSB +: 4] = state;
        end
        `REG_NET:     next_rdata = pg_net_addr;
        `REG_STATION: next_rdata = {25'h000_0000, multipoint_station_address};
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_CLR_SWEEP_START:
    assert property ($rose(ram_clr_we) |-> ram_clr_addr == '0)
    else $error("clear sweep did not start at address zero");
  AST_REMOTE_ONLY_STOP:
    assert property ((state == mode_switch_reset_sequencer_pkg::ST_IDLE && run_mode)
                     |=> state != mode_switch_reset_sequencer_pkg::ST_CLEAR)
    else $error("clear started outside STOP");
  AST_HOLD_STEADY:
    assert property ((state == mode_switch_reset_sequencer_pkg::ST_HOLD && sel_memory_clear_position
                      && steady_cnt == 3'd0 && timer == HOLD_CYC - 40'h00_0000_0001)
                     |=> steady ##1 led.stop)
    else $error("stop indicator not steady after hold");
  AST_CLR_BLINK:
    assert property ((state == mode_switch_reset_sequencer_pkg::ST_CLEAR && !fw_mode)
                     |=> led.stop == $past(blink_slow))
    else $error("stop indicator not blinking during clear");
  AST_RELOAD_CARD:
    assert property ((state == mode_switch_reset_sequencer_pkg::ST_RELOAD)
                     |=> led.card == $past(blink_slow) && led.stop)
    else $error("card indicator wrong during reload");
  AST_RELOAD_MODE:
    assert property ((state == mode_switch_reset_sequencer_pkg::ST_RELOAD && card_reload_done)
                     |=> state == mode_switch_reset_sequencer_pkg::ST_IDLE
                         && run_mode == $past(sel_run))
    else $error("mode after reload does not follow lever");
  AST_FACT_RUN:
    assert property ($rose(factory) |-> ##[1:2] led.run)
    else $error("run indicator late on restore");
  AST_FACT_SIX:
    assert property ((state == mode_switch_reset_sequencer_pkg::ST_ARMED && memory_clear_position_rise
                      && steady_cnt != `FACT_STEADY) |=> !factory)
    else $error("restore accepted without six steady phases");
  AST_FACT_ADDR:
    assert property ((state == mode_switch_reset_sequencer_pkg::ST_CLEAR && factory)
                     |=> pg_net_addr == `NET_RESET
                         && multipoint_station_address == `STATION_RESET)
    else $error("restore did not reset addresses");
  AST_FW_SKIP:
    assert property ((state == mode_switch_reset_sequencer_pkg::ST_BOOT
                      && card_pkg.version == installed_version)
                     |=> state != mode_switch_reset_sequencer_pkg::ST_FW_OFFER)
    else $error("offer shown for equal version");
  AST_FW_CLEAR:
    assert property ((state == mode_switch_reset_sequencer_pkg::ST_FW_WRITE && fw_write_done)
                     |=> state == mode_switch_reset_sequencer_pkg::ST_CLEAR && fw_mode)
    else $error("firmware write not followed by clear");
  AST_FW_WRITE_IND:
    assert property ((state == mode_switch_reset_sequencer_pkg::ST_FW_WRITE)
                     |=> led.card && (led.fault != led.force_ind))
    else $error("indicators wrong during firmware write");

endmodule : mode_switch_reset_sequencer

// ### rtl/mode_switch_reset_sequencer_map.svh
`ifndef MODE_SWITCH_RESET_SEQUENCER_MAP_SVH
`define MODE_SWITCH_RESET_SEQUENCER_MAP_SVH

// Clock rate in kHz, so that a time in ms times this gives cycles
`define CLK_KHZ        40'd250000

// Times in milliseconds
`define HOLD_MS        40'd3000
`define TAP_MS         40'd3000
`define FACT_TAP_MS    40'd1000
`define FW_OFFER_MS    40'd10000
`define BOOT_MS        40'd500
`define PHASE_MS       40'd2500
`define DEBOUNCE_MS    40'd10

// Steady phases that arm a factory restore
`define FACT_STEADY    3'd6

// Register offsets (byte addresses)
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_NET        8'h08
`define REG_STATION    8'h0C

// Field positions
`define CTRL_CLEAR_BIT 0
`define STAT_RUN_BIT   0
`define STAT_FWERR_BIT 1
`define STAT_FACT_BIT  2
`define STAT_STATE_LSB 4

// Reset values
`define NET_RESET      32'h0000_0000
`define STATION_RESET  7'h02

`endif

// ### rtl/mode_switch_reset_sequencer_pkg.sv
package mode_switch_reset_sequencer_pkg;

  typedef enum logic [3:0] {
    ST_BOOT,
    ST_FW_OFFER,
    ST_FW_WRITE,
    ST_IDLE,
    ST_HOLD,
    ST_ARMED,
    ST_CLEAR,
    ST_RELOAD,
    ST_FW_END
  } seq_state_t;

  typedef struct packed {
    logic power;
    logic stop;
    logic run;
    logic fault;
    logic force_ind;
    logic card;
  } led_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] name;
    logic [15:0] version;
  } pkg_info_t;

endpackage : mode_switch_reset_sequencer_pkg

// ### testbench/card_partner.sv
`timescale 1ns/10ps
module card_partner (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic fail_write,
  input  wire logic card_reload_req,
  output logic      card_reload_done,
  input  wire logic fw_write_req,
  output logic      fw_write_done,
  output logic      fw_write_err
);
  logic [3:0] cnt;
  // A failed write is flagged together with its done pulse
  // answer each request once, eight cycles late
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt              <= 4'h0;
      card_reload_done <= 1'b0;
      fw_write_done    <= 1'b0;
      fw_write_err     <= 1'b0;
    end
    else
    begin
      card_reload_done <= 1'b0;
      fw_write_done    <= 1'b0;
      fw_write_err     <= 1'b0;
      if ((card_reload_req || fw_write_req) && !card_reload_done && !fw_write_done)
      begin
        cnt <= cnt + 4'h1;
        if (cnt == 4'h7)
        begin
          cnt              <= 4'h0;
          card_reload_done <= card_reload_req;
          fw_write_done    <= fw_write_req;
          fw_write_err     <= fw_write_req & fail_write;
        end
      end
    end
  end
endmodule : card_partner

// ### testbench/test_mode_switch_reset_sequencer.sv
`timescale 1ns/10ps
module test_mode_switch_reset_sequencer;
  logic core_clk = 0, rst = 1, run_pin = 0, clr_pin = 0, card_cmd = 0, card_in = 1, fw_bad = 0;
  logic [15:0] inst_ver = 16'h0001;
  logic reg_wr = 0, reg_rd = 0, rel_req, rel_done, fw_req, fw_done, fw_err, ram_we, run_mode;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, net, rdata;
  logic [3:0]  ram_addr;
  logic [6:0]  station;
  mode_switch_reset_sequencer_pkg::pkg_info_t card_pkg = '0;
  mode_switch_reset_sequencer_pkg::led_t      led;
  int err_count = 0, num_checks = 0, n;
  mode_switch_reset_sequencer #(.RAM_AW(4), .BLINK_W(4), .HOLD_CYC(40'd40), .TAP_CYC(40'd40),
    .FTAP_CYC(40'd40), .OFFER_CYC(40'd60), .BOOT_CYC(40'd20), .PHASE_CYC(40'd20),
    .DEB_CYC(40'd4)) dut (.core_clk(core_clk), .rst(rst), .run_position_pin(run_pin),
    .memory_clear_position_pin(clr_pin), .card_present(card_in), .card_cmd_factory(card_cmd),
    .card_pkg(card_pkg), .installed_version(inst_ver), .card_reload_req(rel_req),
    .card_reload_done(rel_done), .fw_write_req(fw_req), .fw_write_done(fw_done),
    .fw_write_err(fw_err), .ram_clr_we(ram_we), .ram_clr_addr(ram_addr), .pg_net_addr(net),
    .multipoint_station_address(station), .run_mode(run_mode), .led(led),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata));
  card_partner partner (.core_clk(core_clk), .rst(rst), .fail_write(fw_bad), .card_reload_req(rel_req),
    .card_reload_done(rel_done), .fw_write_req(fw_req), .fw_write_done(fw_done),
    .fw_write_err(fw_err));
  initial forever #2 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  task do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
  endtask : do_reset
  task idle(input int k);
    repeat (k) @(posedge core_clk);
  endtask : idle
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    check(rdata, exp);
  endtask : rd
  // Length of the next clear sweep in cycles; 0 if none starts
  task clear_len(output int len);
    len = 0;
    n   = 0;
    while (ram_we !== 1'b1 && n < 300)
    begin
      @(negedge core_clk);
      n++;
    end
    while (ram_we === 1'b1 && len < 100)
    begin
      @(negedge core_clk);
      len++;
    end
  endtask : clear_len
  task end_reload;
    n = 0;
    while (rel_req !== 1'b0 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    idle(3);
    @(negedge core_clk);
  endtask : end_reload
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    idle(20000);
    err_count++;
    conclude();
  end
  initial
  begin
    int len;
    do_reset();
    @(negedge core_clk);
    check(led, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0002);
    rd(8'h10, 32'h0000_0000);
    idle(30);
    wr(8'h08, 32'hC0A8_0001);
    rd(8'h08, 32'hC0A8_0001);
    wr(8'h00, 32'h0000_0001);
    clear_len(len);
    check(len, 16);
    end_reload();
    check({led.stop, led.card, run_mode}, 32'h0000_0004);
    wr(8'h00, 32'h0000_0001);
    run_pin <= 1'b1;
    clear_len(len);
    end_reload();
    check(run_mode, 1'b1);
    wr(8'h00, 32'h0000_0001);
    idle(5);
    @(negedge core_clk);
    check(ram_we, 1'b0);
    run_pin <= 1'b0;
    idle(10);
    wr(8'h0C, 32'h0000_0005);
    card_in <= 1'b0;
    wr(8'h00, 32'h0000_0001);
    clear_len(len);
    check(len, 16);
    check(rel_req, 1'b0);
    card_in <= 1'b1;
    card_cmd <= 1'b1;
    @(posedge core_clk);
    card_cmd <= 1'b0;
    clear_len(len);
    end_reload();
    check(led.run, 1'b1);
    rd(8'h08, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0002);
    clr_pin <= 1'b1;
    idle(50);
    @(negedge core_clk);
    check(led.stop, 1'b1);
    idle(3);
    @(negedge core_clk);
    check(led.stop, 1'b1);
    clr_pin <= 1'b0;
    idle(10);
    clr_pin <= 1'b1;
    clear_len(len);
    check(len, 16);
    clr_pin <= 1'b0;
    end_reload();
    check(led.run, 1'b0);
    clr_pin <= 1'b1;
    idle(255);
    clr_pin <= 1'b0;
    idle(10);
    clr_pin <= 1'b1;
    clear_len(len);
    check(len, 16);
    clr_pin <= 1'b0;
    end_reload();
    check(led.run, 1'b1);
    rd(8'h04, 32'h0000_0034);
    card_pkg <= '{valid: 1'b1, name: "px000035", version: 16'h0002};
    do_reset();
    idle(30);
    @(negedge core_clk);
    check(led.fault ^ led.force_ind, 1'b1);
    clr_pin <= 1'b1;
    idle(10);
    @(negedge core_clk);
    check({fw_req, led.card}, 32'h0000_0003);
    clr_pin <= 1'b0;
    clear_len(len);
    check(len, 16);
    idle(20);
    @(negedge core_clk);
    check({led.power, led.stop, led.fault, led.force_ind, led.card}, 32'h0000_001F);
    inst_ver <= 16'h0002;
    do_reset();
    idle(30);
    clr_pin <= 1'b1;
    idle(10);
    @(negedge core_clk);
    check(fw_req, 1'b0);
    clr_pin <= 1'b0;
    inst_ver <= 16'h0001;
    fw_bad <= 1'b1;
    do_reset();
    idle(30);
    clr_pin <= 1'b1;
    clear_len(len);
    check(len, 16);
    idle(20);
    @(negedge core_clk);
    n = led.power;
    check({led.power, led.stop, led.fault, led.force_ind, led.card}, n ? 32'h1F : 32'h0);
    idle(2);
    @(negedge core_clk);
    check(led.power, n ? 1'b0 : 1'b1);
    rd(8'h04, 32'h0000_0082);
    conclude();
  end
endmodule : test_mode_switch_reset_sequencer
